// File: xmb_bus_ctrl.sv
// What this block does
// R01: Port 0 carries low address, then data.
// R02: Port 2 carries high address every access.
// R03: ALE each six periods, skipped in data transfer.
// R04: Outside latch holds low address from ALE.
// R05: Program strobe each external fetch slot only.
// R06: Program strobe stays high for internal code.
// R07: Select high: below 4096 internal, else external.
// R08: Select low: all fetches go external.
// R09: Write drives data and pulses write strobe.
// R10: Read pulses read strobe; memory drives port.
// R11: Reset pin high two machine cycles resets.
// R12: Read/write strobes need their port latch at 1.
// R13: Data space spans 64K over two ports.
// R14: Program space spans 64K over two ports.
// R15: Strobes of fetch and data never overlap.
//
// Purpose: External program and data memory bus controller.
// Assumes: One ref_clk period is one oscillator period.
// Notes: Every slot lasts six periods; a data access takes two.
`timescale 1ns/100ps
`include "xmb_defines.svh"

module xmb_bus_ctrl #(
   parameter int AW = `XMB_AW,
   parameter int DW = `XMB_DW
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic rst_pin,
   input wire logic ext_access_select,
   input wire logic p3_rd_latch,
   input wire logic p3_wr_latch,
   input wire xmb_pkg::xmb_req_t core_req,
   output logic req_taken,
   output xmb_pkg::xmb_rsp_t core_rsp,
   output logic core_reset,
   output logic [DW-1:0] p0_out,
   output logic p0_oe,
   input wire logic [DW-1:0] p0_in,
   output logic [AW-DW-1:0] p2_out,
   output logic ale,
   output logic prog_store_strobe_n,
   output logic rd_n,
   output logic wr_n
);
   import xmb_pkg::*;

   // ==========================================
   // Elaboration checks
   generate
      if (AW != `XMB_AW || DW != `XMB_DW) begin : g_bad
         $error("Bus widths must match the packed request types");
      end
   endgenerate

   // ==========================================
   // Helpers

   // True while phase ph lies in lo..hi
   function automatic logic in_win(
      input logic [`XMB_PH_W-1:0] ph,
      input logic [`XMB_PH_W-1:0] lo,
      input logic [`XMB_PH_W-1:0] hi
   );
      in_win = (ph >= lo) && (ph <= hi);
   endfunction : in_win

   // Fetch must leave the chip for this address
   function automatic logic fetch_ext(
      input logic sel,
      input logic [AW-1:0] a
   );
      fetch_ext = !sel || (a >= `XMB_INT_ROM_TOP); // R07 R08
   endfunction : fetch_ext

   // ==========================================
   // Declarations
   logic bus_rst; // Qualified reset from pin
   logic ea_s; // Synchronised access select
   logic [DW-1:0] p0_s; // Synchronised port 0 input
   xmb_state_t state_r; // Current slot kind
   xmb_state_t state_nxt;
   logic [`XMB_PH_W-1:0] phase_r; // Phase within slot
   logic [`XMB_PH_W-1:0] phase_nxt;
   xmb_req_t cur_r; // Request being served
   xmb_req_t cur_nxt;
   logic ext_r; // Current fetch goes off chip
   logic ext_nxt;
   logic take; // Request taken this cycle
   logic slot_end; // Last phase of a slot
   logic ale_nxt;
   logic prog_store_strobe_n_n_nxt;
   logic rd_n_nxt;
   logic wr_n_nxt;
   logic p0_oe_nxt;
   logic [DW-1:0] p0_out_nxt;
   logic [AW-DW-1:0] p2_nxt;
   xmb_rsp_t rsp_nxt;

   // ==========================================
   // Pin qualification

   // Reset pin must stand high long enough
   xmb_rst_filter u_rst (
      .ref_clk(ref_clk),
      .reset(reset),
      .rst_pin(rst_pin),
      .hold_r(bus_rst)
   );

   // Select pin may change at any time
   xmb_sync2 #(.W(1)) u_ea (
      .ref_clk(ref_clk),
      .reset(reset),
      .d(ext_access_select),
      .q(ea_s)
   );

   // Port 0 read data; two flops of latency fit the slot
   xmb_sync2 #(.W(DW)) u_p0 (
      .ref_clk(ref_clk),
      .reset(reset),
      .d(p0_in),
      .q(p0_s)
   );

   // Core sees the same qualified reset
   assign core_reset = bus_rst;

   // ==========================================
   // Slot sequencing

   // Choose next slot at the end of each slot
   always_comb begin
      slot_end = (phase_r == `XMB_PH_LAST);
      phase_nxt = slot_end ? `XMB_PH_FIRST : phase_r + 3'h1;
      state_nxt = state_r;
      cur_nxt = cur_r;
      ext_nxt = ext_r;
      take = 1'b0;
      if (slot_end) begin
         if (state_r == XMB_ST_DADDR) begin
            // Address slot is always followed by its transfer
            state_nxt = XMB_ST_DXFER;
         end else if (core_req.valid) begin
            take = 1'b1;
            cur_nxt = core_req;
            case (core_req.kind)
               XMB_K_FETCH: begin
                  state_nxt = XMB_ST_FETCH; // R14
                  ext_nxt = fetch_ext(ea_s, core_req.addr);
               end
               XMB_K_READ, XMB_K_WRITE: begin
                  state_nxt = XMB_ST_DADDR; // R13
                  ext_nxt = 1'b0;
               end
               default: begin
                  // Unknown kind is dropped as an idle slot
                  state_nxt = XMB_ST_IDLE;
                  ext_nxt = 1'b0;
               end
            endcase
         end else begin
            state_nxt = XMB_ST_IDLE;
            ext_nxt = 1'b0;
         end
      end
   end

   // ==========================================
   // Pin values for the coming cycle

   // Decoded from next slot and phase, so pins are registered
   always_comb begin
      ale_nxt = 1'b0;
      prog_store_strobe_n_n_nxt = 1'b1;
      // Latch bit at 0 holds its pin low outside strobes too
      rd_n_nxt = p3_rd_latch; // R12
      wr_n_nxt = p3_wr_latch; // R12
      p0_oe_nxt = 1'b0;
      p0_out_nxt = '0;
      p2_nxt = p2_out;
      case (state_nxt)
         XMB_ST_IDLE: begin
            // Latch pulse keeps its rhythm when bus is quiet
            ale_nxt = in_win(phase_nxt, `XMB_PH_FIRST,
                             `XMB_ALE_END); // R03
         end
         XMB_ST_FETCH: begin
            ale_nxt = in_win(phase_nxt, `XMB_PH_FIRST,
                             `XMB_ALE_END); // R03 R04
            p2_nxt = cur_nxt.addr[AW-1:DW]; // R02
            if (in_win(phase_nxt, `XMB_PH_FIRST, `XMB_ADR_END)) begin
               p0_oe_nxt = 1'b1; // R01
               p0_out_nxt = cur_nxt.addr[DW-1:0];
            end
            // Strobe only after address is off port 0
            prog_store_strobe_n_n_nxt = !(ext_nxt && in_win(phase_nxt,
                           `XMB_PS_BEG, `XMB_PS_END)); // R05 R06
         end
         XMB_ST_DADDR: begin
            ale_nxt = in_win(phase_nxt, `XMB_PH_FIRST,
                             `XMB_ALE_END); // R03 R04
            p2_nxt = cur_nxt.addr[AW-1:DW]; // R02
            if (in_win(phase_nxt, `XMB_PH_FIRST, `XMB_ADR_END)) begin
               p0_oe_nxt = 1'b1; // R01
               p0_out_nxt = cur_nxt.addr[DW-1:0];
            end
         end
         XMB_ST_DXFER: begin
            // No latch pulse: the outside latch must keep address
            p2_nxt = cur_nxt.addr[AW-1:DW]; // R02
            if (cur_nxt.kind == XMB_K_WRITE) begin
               p0_oe_nxt = 1'b1; // R01 R09
               p0_out_nxt = cur_nxt.wdata;
               // Port latch at 0 holds the pin low instead
               wr_n_nxt = p3_wr_latch ? !in_win(phase_nxt,
                          `XMB_RW_BEG, `XMB_RW_END) : 1'b0; // R09 R12
            end else begin
               rd_n_nxt = p3_rd_latch ? !in_win(phase_nxt,
                          `XMB_RW_BEG, `XMB_RW_END) : 1'b0; // R10 R12
            end
            // Program strobe stays high in this slot
            prog_store_strobe_n_n_nxt = 1'b1; // R15
         end
         default: begin
            // Illegal code: leave every strobe idle
            ale_nxt = 1'b0;
         end
      endcase
   end

   // ==========================================
   // Answer to the core

   // Port 0 is taken at the slot end through two flops, so the byte is from phase 3, strobe low
   always_comb begin
      rsp_nxt = '0;
      if (slot_end) begin
         case (state_r)
            XMB_ST_FETCH: begin
               rsp_nxt.valid = 1'b1;
               rsp_nxt.internal = !ext_r;
               rsp_nxt.rdata = ext_r ? p0_s : '0;
            end
            XMB_ST_DXFER: begin
               rsp_nxt.valid = 1'b1;
               if (cur_r.kind == XMB_K_READ) begin
                  rsp_nxt.rdata = p0_s; // R10
               end
            end
            default: begin
               rsp_nxt.valid = 1'b0;
            end
         endcase
      end
   end

   // ==========================================
   // Sequencer state
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_r <= XMB_ST_IDLE;
         // Slot end first, so the first latch pulse is full width
         phase_r <= `XMB_PH_LAST;
         cur_r <= '0;
         ext_r <= 1'b0;
      end else if (bus_rst) begin
         state_r <= XMB_ST_IDLE; // R11
         phase_r <= `XMB_PH_LAST;
         cur_r <= '0;
         ext_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         phase_r <= phase_nxt;
         cur_r <= cur_nxt;
         ext_r <= ext_nxt;
      end
   end

   // ==========================================
   // Bus pins, all registered
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ale <= 1'b0;
         prog_store_strobe_n <= 1'b1;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         p0_oe <= 1'b0;
         p0_out <= '0;
         p2_out <= '0;
      end else if (bus_rst) begin
         ale <= 1'b0; // R11
         prog_store_strobe_n <= 1'b1;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         p0_oe <= 1'b0;
         p0_out <= '0;
         p2_out <= '0;
      end else begin
         ale <= ale_nxt;
         prog_store_strobe_n <= prog_store_strobe_n_n_nxt;
         rd_n <= rd_n_nxt;
         wr_n <= wr_n_nxt;
         p0_oe <= p0_oe_nxt;
         p0_out <= p0_out_nxt;
         p2_out <= p2_nxt;
      end
   end

   // ==========================================
   // Core handshake, one-cycle pulses
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         req_taken <= 1'b0;
         core_rsp <= '0;
      end else if (bus_rst) begin
         req_taken <= 1'b0;
         core_rsp <= '0;
      end else begin
         req_taken <= take;
         core_rsp <= rsp_nxt;
      end
   end

endmodule : xmb_bus_ctrl

// File: xmb_defines.svh
// Purpose: Shared constants of the external memory bus block.
// Assumes: One ref_clk period stands for one oscillator period.
// Notes: Phases count 0..5 within a six-period bus slot.
`ifndef XMB_DEFINES_SVH
`define XMB_DEFINES_SVH

// ==========================================
// Widths
`define XMB_AW 16
`define XMB_DW 8
`define XMB_PH_W 3

// ==========================================
// Slot timing, in phases of one slot
`define XMB_PH_FIRST 3'h0
`define XMB_PH_LAST 3'h5
`define XMB_ALE_END 3'h1
`define XMB_ADR_END 3'h1
`define XMB_PS_BEG 3'h2
`define XMB_PS_END 3'h4
`define XMB_RW_BEG 3'h1
`define XMB_RW_END 3'h4

// ==========================================
// Memory map and reset timing
`define XMB_INT_ROM_TOP 16'h1000
`define XMB_OSC_PER_CLK 1
`define XMB_MCYC_OSC 12
`define XMB_RST_MCYC 2
`define XMB_RST_CLKS (`XMB_MCYC_OSC * `XMB_RST_MCYC * `XMB_OSC_PER_CLK)

`endif

// File: xmb_pkg.sv
// Purpose: Types shared by the external memory bus block.
// Assumes: Widths come from xmb_defines.svh.
// Notes: Request and answer travel as packed structs.
`include "xmb_defines.svh"

package xmb_pkg;

   // ==========================================
   // Kinds of bus request
   typedef enum logic [1:0] {
      XMB_K_FETCH = 2'h0,
      XMB_K_READ = 2'h1,
      XMB_K_WRITE = 2'h2
   } xmb_kind_t;

   // Request from the core, held until taken
   typedef struct packed {
      logic valid;
      xmb_kind_t kind;
      logic [`XMB_AW-1:0] addr;
      logic [`XMB_DW-1:0] wdata;
   } xmb_req_t;

   // Answer to the core, one-cycle pulse
   typedef struct packed {
      logic valid;
      logic internal;
      logic [`XMB_DW-1:0] rdata;
   } xmb_rsp_t;

   // ==========================================
   // Slot kinds, one-hot
   typedef enum logic [3:0] {
      XMB_ST_IDLE = 4'h1,
      XMB_ST_FETCH = 4'h2,
      XMB_ST_DADDR = 4'h4,
      XMB_ST_DXFER = 4'h8
   } xmb_state_t;

endpackage : xmb_pkg

// File: xmb_sync2.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes: The first stage feeds only the second.
`timescale 1ns/100ps

module xmb_sync2 #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r; // First stage, read by q only

   // ==========================================
   // Two stages
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule : xmb_sync2

// File: xmb_rst_filter.sv
// Purpose: Qualifies the reset pin over two machine cycles.
// Assumes: Oscillator runs, so ref_clk toggles.
// Notes: Short glitches on the pin never reset the bus.
`timescale 1ns/100ps
`include "xmb_defines.svh"

module xmb_rst_filter #(
   parameter int HOLD_CLKS = `XMB_RST_CLKS
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic rst_pin,
   output logic hold_r
);

   localparam int CW = $clog2(HOLD_CLKS + 1);

   logic pin_s; // Synchronised pin level
   logic [CW-1:0] cnt_r; // Cycles the pin has stood high

   generate
      if (HOLD_CLKS < 1) begin : g_bad
         $error("HOLD_CLKS must be at least one");
      end
   endgenerate

   xmb_sync2 #(.W(1)) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .d(rst_pin),
      .q(pin_s)
   );

   // ==========================================
   // Count high cycles; release as soon as pin drops
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cnt_r <= '0;
         hold_r <= 1'b0;
      end else if (!pin_s) begin
         cnt_r <= '0;
         hold_r <= 1'b0;
      end else if (cnt_r != CW'(HOLD_CLKS)) begin
         cnt_r <= cnt_r + CW'(1);
      end else begin
         hold_r <= 1'b1; // R11
      end
   end

endmodule : xmb_rst_filter

// File: xmb_bus_chk.sv
// Purpose: Timing checks on the external memory bus pins.
// Assumes: Every pin is sampled on ref_clk.
// Notes: Quiet while either reset holds the bus.
`timescale 1ns/100ps

module xmb_bus_chk
   import xmb_pkg::*;
#(
   parameter int AW = 16,
   parameter int DW = 8
) (
   input logic ref_clk,
   input logic reset,
   input logic rst_pin,
   input logic ext_access_select,
   input logic p3_rd_latch,
   input logic p3_wr_latch,
   input xmb_pkg::xmb_req_t core_req,
   input logic req_taken,
   input xmb_pkg::xmb_rsp_t core_rsp,
   input logic core_reset,
   input logic [DW-1:0] p0_out,
   input logic p0_oe,
   input logic [DW-1:0] p0_in,
   input logic [AW-DW-1:0] p2_out,
   input logic ale,
   input logic prog_store_strobe_n,
   input logic rd_n,
   input logic wr_n
);
   // ==========================================
   // Slot framing and strobes
   default clocking @(posedge ref_clk); endclocking
   // Both resets hold the bus, so nothing is judged then
   default disable iff (reset || core_reset);

   a_ale_width: assert property ($rose(ale) |=> ale ##1 !ale)
      else $error("ale pulse width wrong");
   a_ale_spacing: assert property ($rose(ale) |=> (!$rose(ale)) [*5])
      else $error("ale pulses closer than six periods");
   a_ale_bound: assert property ($rose(ale) |-> ##[6:12] $rose(ale))
      else $error("ale pulse missing");
   a_ale_addr: assert property (req_taken |-> (ale && p0_oe
      && p0_out == $past(core_req.addr[DW-1:0])
      && p2_out == $past(core_req.addr[AW-1:DW])) ##1 (ale && p0_oe))
      else $error("port 0 not driven with ale");
   a_no_ale_xfer: assert property (ale && p3_rd_latch
      && $past(p3_rd_latch) && p3_wr_latch && $past(p3_wr_latch)
      |-> rd_n && wr_n)
      else $error("ale during data transfer");
   a_prog_store_strobe_n_len: assert property ($fell(prog_store_strobe_n)
      |-> !prog_store_strobe_n [*3] ##1 prog_store_strobe_n)
      else $error("program strobe length wrong");
   a_prog_store_strobe_n_after: assert property ($fell(prog_store_strobe_n)
      |-> $past(ale) && !ale && !p0_oe)
      else $error("program strobe before address phase ends");
   a_strobe_excl: assert property (!prog_store_strobe_n && p3_rd_latch
      && $past(p3_rd_latch) && p3_wr_latch && $past(p3_wr_latch)
      |-> rd_n && wr_n)
      else $error("fetch and data strobes overlap");
   a_rd_len: assert property ($fell(rd_n) && p3_rd_latch
      |-> !rd_n [*4] ##1 rd_n)
      else $error("read strobe length wrong");
   a_rd_float: assert property (!rd_n && p3_rd_latch
      && $past(p3_rd_latch) |-> !p0_oe)
      else $error("port 0 driven during read");
   a_wr_hold: assert property (!wr_n && p3_wr_latch
      && $past(p3_wr_latch) |-> p0_oe && $stable(p0_out))
      else $error("write data not held");
   a_rsp_bound: assert property (req_taken |-> ##[6:12] core_rsp.valid)
      else $error("answer missing after take");
   a_int_quiet: assert property (core_rsp.valid && core_rsp.internal
      |-> $past(prog_store_strobe_n, 3) && $past(prog_store_strobe_n, 4))
      else $error("program strobe on internal fetch");
endmodule : xmb_bus_chk

bind xmb_bus_ctrl xmb_bus_chk #(.AW(AW), .DW(DW)) i_xmb_bus_chk (
   .ref_clk(ref_clk), .reset(reset), .rst_pin(rst_pin),
   .ext_access_select(ext_access_select), .p3_rd_latch(p3_rd_latch),
   .p3_wr_latch(p3_wr_latch), .core_req(core_req), .req_taken(req_taken),
   .core_rsp(core_rsp), .core_reset(core_reset), .p0_out(p0_out),
   .p0_oe(p0_oe), .p0_in(p0_in), .p2_out(p2_out), .ale(ale),
   .prog_store_strobe_n(prog_store_strobe_n), .rd_n(rd_n), .wr_n(wr_n));

// File: xmb_mem_model.sv
// Purpose: External memory with address latch on the bus.
// Assumes: The latch follows port 0 while ale is high.
// Notes: Undriven port 0 shows the inverse of its last level.
`timescale 1ns/100ps

module xmb_mem_model (
   input logic ref_clk,
   input logic ale,
   input logic [7:0] p0_out,
   input logic p0_oe,
   input logic [7:0] p2_out,
   input logic prog_store_strobe_n,
   input logic rd_n,
   input logic wr_n,
   output logic [7:0] p0_in
);
   logic [7:0] mem [0:65535]; // Code and data share one array
   logic [7:0] lo_r = 8'h00; // Latched low address
   logic [7:0] last_r = 8'h00; // Last level seen on port 0
   logic [7:0] drv; // What the memory puts on port 0

   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
      end
   end

   // ==========================================
   // Address latch
   always @(posedge ref_clk) begin
      if (ale === 1'b1) begin
         lo_r <= p0_out;
      end
      last_r <= p0_in;
   end

   // Drive only inside a strobe, else a changing pattern
   always_comb begin
      if (!prog_store_strobe_n || !rd_n) begin
         drv = mem[{p2_out, lo_r}];
      end else begin
         drv = ~last_r;
      end
   end
   assign p0_in = p0_oe ? p0_out : drv;

   // Store on the rising edge of the write strobe
   always @(posedge wr_n) begin
      if (p0_oe === 1'b1) begin
         mem[{p2_out, lo_r}] = p0_out;
      end
   end
endmodule : xmb_mem_model

// File: tb.sv
// Purpose: Self-checking bench for the external memory bus.
// Assumes: Memory model answers inside the strobe windows.
// Notes: Requests are held until taken, then dropped.
`timescale 1ns/100ps

module tb;
   import xmb_pkg::*;
   // ==========================================
   // Pins and counters
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic rst_pin = 1'b0;
   logic ext_access_select = 1'b0;
   logic p3_rd_latch = 1'b1;
   logic p3_wr_latch = 1'b1; // Write latch starts set; t_latch clears it for two requests
   xmb_req_t core_req = '0;
   xmb_rsp_t core_rsp, rsp;
   logic req_taken, core_reset, p0_oe, ale, prog_store_strobe_n, rd_n, wr_n;
   logic [7:0] p0_out, p0_in, p2_out;
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;
   int rd_low = 0; // Cycles with read strobe low
   int ps_low = 0; // Cycles with program strobe low
   int crst = 0; // Cycles with core reset high

   always #10 ref_clk = ~ref_clk;

   xmb_bus_ctrl i_xmb_bus_ctrl (.ref_clk(ref_clk), .reset(reset),
      .rst_pin(rst_pin), .ext_access_select(ext_access_select),
      .p3_rd_latch(p3_rd_latch), .p3_wr_latch(p3_wr_latch),
      .core_req(core_req), .req_taken(req_taken), .core_rsp(core_rsp),
      .core_reset(core_reset), .p0_out(p0_out), .p0_oe(p0_oe),
      .p0_in(p0_in), .p2_out(p2_out), .ale(ale),
      .prog_store_strobe_n(prog_store_strobe_n), .rd_n(rd_n), .wr_n(wr_n));
   xmb_mem_model i_xmb_mem_model (.ref_clk(ref_clk), .ale(ale),
      .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out),
      .prog_store_strobe_n(prog_store_strobe_n), .rd_n(rd_n), .wr_n(wr_n),
      .p0_in(p0_in));

   // Mid-cycle counts, away from the launching edge
   always @(negedge ref_clk) begin
      if (rd_n === 1'b0) rd_low++;
      if (prog_store_strobe_n === 1'b0) ps_low++;
      if (core_reset === 1'b1) crst++;
   end

   // Hang guard, far above the expected run length
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         test_done();
      end
   end

   // ==========================================
   // Compares and bus task
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t byte %h expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t bit %b expected %b", $time, got, exp);
      end
   endtask : chk1

   task automatic do_req(input xmb_kind_t k, input logic [15:0] a,
      input logic [7:0] d);
      int i;
      @(posedge ref_clk);
      core_req <= '{1'b1, k, a, d};
      for (i = 0; i < 20; i++) begin
         @(negedge ref_clk);
         if (req_taken === 1'b1) break;
      end
      chk1(req_taken, 1'b1);
      chk1(ale, 1'b1);
      chk8(p0_out, a[7:0]);
      chk8(p2_out, a[15:8]);
      @(posedge ref_clk);
      core_req.valid <= 1'b0;
      for (i = 0; i < 20; i++) begin
         @(negedge ref_clk);
         if (core_rsp.valid === 1'b1) break;
      end
      rsp = core_rsp;
      chk1(rsp.valid, 1'b1);
   endtask : do_req

   // ==========================================
   // Scenarios
   task automatic t_ext;
      @(posedge ref_clk);
      ext_access_select <= 1'b0;
      repeat (4) @(posedge ref_clk);
      do_req(XMB_K_FETCH, 16'h0123, 8'h00);
      chk1(rsp.internal, 1'b0);
      chk8(rsp.rdata, 8'h1e);
      do_req(XMB_K_FETCH, 16'hfffe, 8'h00);
      chk8(rsp.rdata, 8'h3d);
      $display("test ext done");
   endtask : t_ext

   task automatic t_select;
      @(posedge ref_clk);
      ext_access_select <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ps_low = 0;
      do_req(XMB_K_FETCH, 16'h0fff, 8'h00);
      chk1(rsp.internal, 1'b1);
      chk1(ps_low == 0, 1'b1);
      do_req(XMB_K_FETCH, 16'h1000, 8'h00);
      chk1(rsp.internal, 1'b0);
      chk8(rsp.rdata, 8'h2c);
      chk1(ps_low == 3, 1'b1);
      $display("test select done");
   endtask : t_select

   task automatic t_data;
      rd_low = 0;
      ps_low = 0;
      do_req(XMB_K_WRITE, 16'hffff, 8'ha5);
      do_req(XMB_K_READ, 16'hffff, 8'h00);
      chk8(rsp.rdata, 8'ha5);
      chk1(rd_low == 4, 1'b1);
      do_req(XMB_K_READ, 16'h8001, 8'h00);
      chk8(rsp.rdata, 8'hbd);
      chk1(ps_low == 0, 1'b1);
      $display("test data done");
   endtask : t_data

   task automatic t_latch;
      @(posedge ref_clk);
      p3_rd_latch <= 1'b0;
      p3_wr_latch <= 1'b0;
      rd_low = 0;
      do_req(XMB_K_READ, 16'h0040, 8'h00);
      chk1(rd_low > 12, 1'b1);
      // Write strobe disabled: memory must keep its old byte
      do_req(XMB_K_WRITE, 16'h0040, 8'h5a);
      @(posedge ref_clk);
      p3_rd_latch <= 1'b1;
      p3_wr_latch <= 1'b1;
      do_req(XMB_K_READ, 16'h0040, 8'h00);
      chk8(rsp.rdata, 8'h7c);
      $display("test latch done");
   endtask : t_latch

   task automatic t_rst;
      crst = 0;
      @(posedge ref_clk);
      rst_pin <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rst_pin <= 1'b0;
      repeat (40) @(posedge ref_clk);
      chk1(crst == 0, 1'b1);
      rst_pin <= 1'b1;
      repeat (40) @(posedge ref_clk);
      chk1(crst > 5, 1'b1);
      rst_pin <= 1'b0;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      chk1(core_reset, 1'b0);
      do_req(XMB_K_FETCH, 16'h2000, 8'h00);
      chk8(rsp.rdata, 8'h1c);
      $display("test reset pin done");
   endtask : t_rst

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      t_ext();
      t_select();
      t_data();
      t_latch();
      t_rst();
      test_done();
   end
endmodule : tb
